// ===== rtl/uep_pkg.sv
// Constants, register map and types of the endpoint control and receive status block.
// Assumes one clock domain; the APB master and the USB token decoder share CORE_CLK.
//
// Functional notes
// - Stall bit stalls IN (tx enabled) and OUT
// - Stall bit never stalls a SETUP token
// - Isochronous endpoint never answers NAK
// - Enabled endpoint matches address plus endpoint number
// - Disabled endpoint ignores every token silently
// - Endpoint number in low bits, fields reset zero
// - Data port returns next payload byte, low eight
// - PID and CRC16 never enter the FIFO
// - Test mode makes data port writable
// - Media error sets receive error flag
// - Setup flag set on SETUP, cleared on read
// - Non-iso toggle shows last DATA PID
// - Iso toggle captures frame number LSB
// - Status read clears toggle bit
// - Receive-complete set on ACK, cleared on read
// - Byte count saturates at fifteen
// - Flush waits for reception, clears FIFO, idles

`default_nettype none

package uep_pkg;

   // Register indices; byte address is four times the index
   localparam logic [31:0] EP_CFG_IDX   = 32'h50001878; // endpoint6_config
   localparam logic [31:0] RX_DATA_IDX  = 32'h5000187a; // endpoint3_rx_data_port
   localparam logic [31:0] RX_STS_IDX   = 32'h5000187c; // endpoint3_rx_status
   localparam logic [31:0] RX_CTRL_IDX  = 32'h5000187e; // Receive control
   localparam logic [31:0] FUNC_ADR_IDX = 32'h50001880; // function_address_register

   // Configuration word fields
   localparam int CFG_STALL_BIT = 7;
   localparam int CFG_ISO_BIT   = 5;
   localparam int CFG_EN_BIT    = 4;
   localparam logic [15:0] CFG_WMASK = 16'h00bf; // Writable bits only
   localparam logic [15:0] CFG_RESET = 16'h0000;

   // Receive control fields
   localparam int CTL_RXEN_BIT  = 0;
   localparam int CTL_IGNS_BIT  = 2;
   localparam int CTL_FLUSH_BIT = 3;
   localparam int CTL_TEST_BIT  = 8;

   // Status word fields
   localparam int STS_ERR_BIT   = 7;
   localparam int STS_SETUP_BIT = 6;
   localparam int STS_TOG_BIT   = 5;
   localparam int STS_LAST_BIT  = 4;
   localparam logic [3:0] RCOUNT_MAX = 4'hf;

   // Function address field width
   localparam int FADR_W = 7;

   // Data PIDs as they arrive in the first packet byte
   localparam logic [7:0] PID_DATA0 = 8'hc3;
   localparam logic [7:0] PID_DATA1 = 8'h4b;

   // Bytes held back so the trailing CRC16 never reaches the FIFO
   localparam logic [1:0] CRC_BYTES = 2'h2;

   // Default receive FIFO depth
   localparam int RX_DEPTH = 64;

   // Token kinds from the serial decoder
   typedef enum logic [1:0] {TOK_OUT, TOK_IN, TOK_SETUP, TOK_SOF} uep_tok_e;

   // Handshake kinds toward the serial encoder
   typedef enum logic [1:0] {HS_NONE, HS_ACK, HS_NAK, HS_STALL} uep_hs_e;

   // Receive state machine
   typedef enum logic [1:0] {ST_IDLE, ST_RECV, ST_DISCARD} uep_state_e;

endpackage : uep_pkg

`default_nettype wire

// ===== rtl/uep_rx_fifo.sv
// Receive FIFO of the endpoint: byte array with push, pop and flush.
// Ignores a push when full and a pop when empty; the caller may push when full.

`default_nettype none

module uep_rx_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 64
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         flush,
   input  wire logic         push,
   input  wire logic [W-1:0] push_data,
   input  wire logic         pop,
   output logic [W-1:0]      head,
   output logic              full,
   output logic              empty,
   output logic [$clog2(DEPTH):0] count
);

   localparam int AW = $clog2(DEPTH);

   logic [W-1:0]  mem [DEPTH];     // Byte storage
   logic [AW-1:0] wptr_q;          // Write pointer
   logic [AW-1:0] rptr_q;          // Read pointer
   logic [AW:0]   cnt_q;           // Fill level

   // Storage writes; no reset needed for data
   always_ff @(posedge clk)
   begin
      if (push && !full)
      begin
         mem[wptr_q] <= push_data;
      end
   end

   // Pointers and level; flush returns both pointers to zero
   always_ff @(posedge clk)
   begin
      if (rst || flush)
      begin
         wptr_q <= '0;
         rptr_q <= '0;
         cnt_q  <= '0;
      end
      else
      begin
         if (push && !full)
         begin
            wptr_q <= wptr_q + 1'b1;
         end
         if (pop && !empty)
         begin
            rptr_q <= rptr_q + 1'b1;
         end
         cnt_q <= cnt_q + {{AW{1'b0}}, push && !full} - {{AW{1'b0}}, pop && !empty};
      end
   end

   assign head  = mem[rptr_q];
   assign full  = (cnt_q == (AW+1)'(DEPTH));
   assign empty = (cnt_q == '0);
   assign count = cnt_q;

endmodule : uep_rx_fifo

`default_nettype wire

// ===== rtl/uep_endpoint.sv
// Endpoint control and receive status logic with APB register access.
// Assumes a serial engine that decodes tokens and data bytes (PID first,
// CRC16 last) and encodes the handshake asked for on HS_VALID.

`default_nettype none

module uep_endpoint #(
   parameter int DEPTH = uep_pkg::RX_DEPTH
) (
   input  wire logic              CORE_CLK,
   input  wire logic              RST,
   // APB slave
   input  wire logic              PSEL,
   input  wire logic              PENABLE,
   input  wire logic              PWRITE,
   input  wire logic [31:0]       PADDR,
   input  wire logic [31:0]       PWDATA,
   output logic [31:0]            PRDATA,
   output logic                   PREADY,
   output logic                   PSLVERR,
   // Token from the serial decoder
   input  wire logic              TOK_VALID,
   input  wire uep_pkg::uep_tok_e TOK_KIND,
   input  wire logic [6:0]        TOK_ADDR,
   input  wire logic [3:0]        TOK_EP,
   // Data packet byte stream
   input  wire logic              RX_BYTE_VALID,
   input  wire logic [7:0]        RX_BYTE,
   input  wire logic              RX_END,
   input  wire logic              RX_MEDIA_ERR,
   // Transmit side state and frame number
   input  wire logic              TX_ENABLED,
   input  wire logic              FRAME_LSB,
   // Handshake request
   output logic                   HS_VALID,
   output uep_pkg::uep_hs_e       HS_KIND
);

   import uep_pkg::*;

   // Register state
   logic [15:0]       cfg_q;        // Configuration word
   logic              rx_en_q;      // Receive enable
   logic              ign_setup_q;  // Ignore SETUP tokens
   logic              flush_q;      // Flush pending
   logic              test_q;       // Test mode
   logic [FADR_W-1:0] fadr_q;       // Device address
   logic              err_q;        // Receive error flag
   logic              setup_q;      // Setup flag
   logic              tog_q;        // Toggle or frame LSB
   logic              last_q;       // Receive complete
   logic [31:0]       prdata_q;     // Read data captured in setup phase
   logic              slverr_q;     // Unmapped address seen in setup

   // Receive side
   uep_state_e        state_q;      // Receive state
   uep_hs_e           pend_q;       // Answer owed at packet end
   logic              is_setup_q;   // Current packet follows SETUP
   logic [1:0]        seen_q;       // Packet bytes seen, saturating at three
   logic [7:0]        hold0_q;      // Newest held byte
   logic [7:0]        hold1_q;      // Oldest held byte
   logic [7:0]        pid_q;        // PID of current packet
   logic              ovf_q;        // FIFO overflowed during packet
   logic              hs_v_q;       // Handshake strobe
   uep_hs_e           hs_k_q;       // Handshake kind

   // FIFO wiring
   logic              f_push;
   logic [7:0]        f_wdata;
   logic              f_pop;
   logic              f_flush;
   logic [7:0]        f_head;
   logic              f_full;
   logic              f_empty;
   logic [$clog2(DEPTH):0] f_count;

   // Bus decode
   logic              setup_ph;     // First cycle of a transfer
   logic              access;       // Completing cycle
   logic              hit_cfg;
   logic              hit_dat;
   logic              hit_sts;
   logic              hit_ctl;
   logic              hit_fad;
   logic              wr_cfg;
   logic              wr_ctl;
   logic              rd_sts;
   logic              tok_hit;      // Token addressed to this endpoint
   logic              pkt_done;     // Data packet ends in RECV
   logic [15:0]       sts_word;     // Live status word

   // Saturating byte count for the status word
   function automatic logic [3:0] sat_count(input logic [$clog2(DEPTH):0] n);
      if (n > ($clog2(DEPTH)+1)'(RCOUNT_MAX))
      begin
         return RCOUNT_MAX;
      end
      return n[3:0];
   endfunction : sat_count

   // Address decode against register indices
   always_comb
   begin
      hit_cfg = 1'b0;
      hit_dat = 1'b0;
      hit_sts = 1'b0;
      hit_ctl = 1'b0;
      hit_fad = 1'b0;
      if (PADDR[31:2] == EP_CFG_IDX[29:0])
      begin
         hit_cfg = 1'b1;
      end
      else if (PADDR[31:2] == RX_DATA_IDX[29:0])
      begin
         hit_dat = 1'b1;
      end
      else if (PADDR[31:2] == RX_STS_IDX[29:0])
      begin
         hit_sts = 1'b1;
      end
      else if (PADDR[31:2] == RX_CTRL_IDX[29:0])
      begin
         hit_ctl = 1'b1;
      end
      else if (PADDR[31:2] == FUNC_ADR_IDX[29:0])
      begin
         hit_fad = 1'b1;
      end
   end

   // Zero-wait slave: every access completes in its first access cycle
   assign setup_ph = PSEL && !PENABLE;
   assign access   = PSEL && PENABLE;
   assign wr_cfg   = access && PWRITE && hit_cfg;
   assign wr_ctl   = access && PWRITE && hit_ctl;
   assign rd_sts   = access && !PWRITE && hit_sts;
   assign f_pop    = access && !PWRITE && hit_dat && !f_empty;
   assign PREADY   = 1'b1;
   assign PRDATA   = prdata_q;
   assign PSLVERR  = slverr_q && access;

   // Status word as firmware sees it; reserved bits zero
   always_comb
   begin
      sts_word = '0;
      sts_word[STS_ERR_BIT]   = err_q;
      sts_word[STS_SETUP_BIT] = setup_q;
      sts_word[STS_TOG_BIT]   = tog_q;
      sts_word[STS_LAST_BIT]  = last_q;
      sts_word[3:0]           = sat_count(f_count);
   end

   // Read data is captured in the setup phase so PRDATA comes from a flop
   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         prdata_q <= '0;
         slverr_q <= 1'b0;
      end
      else if (setup_ph)
      begin
         slverr_q <= !(hit_cfg || hit_dat || hit_sts || hit_ctl || hit_fad);
         prdata_q <= '0;
         if (hit_cfg)
         begin
            prdata_q <= {16'h0000, cfg_q};
         end
         else if (hit_dat)
         begin
            prdata_q <= {24'h000000, f_head};
         end
         else if (hit_sts)
         begin
            prdata_q <= {16'h0000, sts_word};
         end
         else if (hit_ctl)
         begin
            prdata_q <= 32'(({23'h0, test_q} << CTL_TEST_BIT) | ({31'h0, flush_q} << CTL_FLUSH_BIT)
                        | ({31'h0, ign_setup_q} << CTL_IGNS_BIT) | ({31'h0, rx_en_q} << CTL_RXEN_BIT));
         end
         else if (hit_fad)
         begin
            prdata_q <= {25'h0, fadr_q};
         end
      end
   end

   // Configuration word; reserved bits never store
   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         cfg_q <= CFG_RESET;
      end
      else if (wr_cfg)
      begin
         cfg_q <= PWDATA[15:0] & CFG_WMASK;
      end
   end

   // Receive control and device address
   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         rx_en_q     <= 1'b0;
         ign_setup_q <= 1'b0;
         test_q      <= 1'b0;
         fadr_q      <= '0;
      end
      else
      begin
         if (wr_ctl)
         begin
            ign_setup_q <= PWDATA[CTL_IGNS_BIT];
            test_q      <= PWDATA[CTL_TEST_BIT];
         end
         // Enable drops after each packet received in RECV or OUT stall; firmware re-arms
         if (wr_ctl && PWDATA[CTL_RXEN_BIT])
         begin
            rx_en_q <= 1'b1;
         end
         else if (wr_ctl)
         begin
            rx_en_q <= 1'b0;
         end
         else if (pkt_done || (tok_hit && TOK_KIND == TOK_OUT && cfg_q[CFG_STALL_BIT]))
         begin
            rx_en_q <= 1'b0;
         end
         if (access && PWRITE && hit_fad)
         begin
            fadr_q <= PWDATA[FADR_W-1:0];
         end
      end
   end

   // Flush request stays pending until the receiver is idle
   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         flush_q <= 1'b0;
      end
      else if (wr_ctl && PWDATA[CTL_FLUSH_BIT])
      begin
         flush_q <= 1'b1;
      end
      else if (f_flush)
      begin
         flush_q <= 1'b0;
      end
   end

   assign f_flush = flush_q && state_q == ST_IDLE;

   // Token match: only an enabled endpoint compares address and number
   assign tok_hit = TOK_VALID && cfg_q[CFG_EN_BIT] && TOK_ADDR == fadr_q
                    && TOK_EP == cfg_q[3:0]
                    && TOK_KIND != TOK_SOF
                    && !(TOK_KIND == TOK_SETUP && ign_setup_q);
   assign pkt_done = state_q == ST_RECV && RX_END;

   // Receive state machine and handshake choice
   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         state_q    <= ST_IDLE;
         pend_q     <= HS_NONE;
         is_setup_q <= 1'b0;
         hs_v_q     <= 1'b0;
         hs_k_q     <= HS_NONE;
      end
      else
      begin
         hs_v_q <= 1'b0;
         case (state_q)
            ST_IDLE:
            begin
               if (tok_hit && TOK_KIND == TOK_IN)
               begin
                  // IN answered at once only when stalled; data is the transmit side's job
                  if (cfg_q[CFG_STALL_BIT] && TX_ENABLED)
                  begin
                     hs_v_q <= 1'b1;
                     hs_k_q <= HS_STALL;
                  end
               end
               else if (tok_hit && TOK_KIND == TOK_SETUP)
               begin
                  // SETUP is taken regardless of stall or receive enable
                  state_q    <= ST_RECV;
                  pend_q     <= HS_ACK;
                  is_setup_q <= 1'b1;
               end
               else if (tok_hit && TOK_KIND == TOK_OUT)
               begin
                  is_setup_q <= 1'b0;
                  if (cfg_q[CFG_STALL_BIT])
                  begin
                     state_q <= ST_DISCARD;
                     pend_q  <= HS_STALL;
                  end
                  else if (rx_en_q && !f_full)
                  begin
                     state_q <= ST_RECV;
                     pend_q  <= cfg_q[CFG_ISO_BIT] ? HS_NONE : HS_ACK;
                  end
                  else
                  begin
                     state_q <= ST_DISCARD;
                     pend_q  <= cfg_q[CFG_ISO_BIT] ? HS_NONE : HS_NAK;
                  end
               end
            end
            ST_RECV, ST_DISCARD:
            begin
               if (RX_END)
               begin
                  state_q <= ST_IDLE;
                  // A damaged packet gets no handshake at all
                  if (!(RX_MEDIA_ERR || (state_q == ST_RECV && ovf_q)) && pend_q != HS_NONE)
                  begin
                     hs_v_q <= 1'b1;
                     hs_k_q <= pend_q;
                  end
               end
            end
            default:
            begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   assign HS_VALID = hs_v_q;
   assign HS_KIND  = hs_k_q;

   // Byte delay line: first byte is the PID, last two never leave the hold
   always_ff @(posedge CORE_CLK)
   begin
      if (RST || state_q != ST_RECV)
      begin
         seen_q  <= '0;
         hold0_q <= '0;
         hold1_q <= '0;
         pid_q   <= '0;
         ovf_q   <= 1'b0;
      end
      else if (RX_BYTE_VALID)
      begin
         if (seen_q == '0)
         begin
            pid_q <= RX_BYTE;
         end
         else
         begin
            hold0_q <= RX_BYTE;
            hold1_q <= hold0_q;
         end
         if (seen_q != CRC_BYTES + 2'h1)
         begin
            seen_q <= seen_q + 2'h1;
         end
         if (f_push && f_full)
         begin
            ovf_q <= 1'b1;
         end
      end
   end

   // Push the oldest held byte once two newer ones stand behind it
   assign f_push  = (state_q == ST_RECV && RX_BYTE_VALID && seen_q == CRC_BYTES + 2'h1)
                    || (test_q && access && PWRITE && hit_dat);
   assign f_wdata = (state_q == ST_RECV) ? hold1_q : PWDATA[7:0];

   // Status flags: a hardware set always beats the read clear
   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         err_q   <= 1'b0;
         setup_q <= 1'b0;
         tog_q   <= 1'b0;
         last_q  <= 1'b0;
      end
      else
      begin
         if (pkt_done && (RX_MEDIA_ERR || ovf_q))
         begin
            err_q <= 1'b1;
         end
         else if (wr_ctl && PWDATA[CTL_FLUSH_BIT])
         begin
            err_q <= 1'b0;
         end
         if (pkt_done && !RX_MEDIA_ERR && is_setup_q)
         begin
            setup_q <= 1'b1;
         end
         else if (rd_sts && prdata_q[STS_SETUP_BIT])
         begin
            setup_q <= 1'b0;
         end
         if (pkt_done && !RX_MEDIA_ERR && !ovf_q)
         begin
            tog_q <= cfg_q[CFG_ISO_BIT] ? FRAME_LSB : (pid_q == PID_DATA1);
         end
         else if (rd_sts && prdata_q[STS_TOG_BIT])
         begin
            tog_q <= 1'b0;
         end
         if (pkt_done && !RX_MEDIA_ERR && !ovf_q && pend_q == HS_ACK)
         begin
            last_q <= 1'b1;
         end
         else if (rd_sts && prdata_q[STS_LAST_BIT])
         begin
            last_q <= 1'b0;
         end
      end
   end

   uep_rx_fifo #(
      .W     (8),
      .DEPTH (DEPTH)
   ) u_fifo (
      .clk       (CORE_CLK),
      .rst       (RST),
      .flush     (f_flush),
      .push      (f_push),
      .push_data (f_wdata),
      .pop       (f_pop),
      .head      (f_head),
      .full      (f_full),
      .empty     (f_empty),
      .count     (f_count)
   );

   // Checks
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);

   sequence s_stalled_in;
      tok_hit && TOK_KIND == TOK_IN && cfg_q[CFG_STALL_BIT] && TX_ENABLED && state_q == ST_IDLE;
   endsequence
   sequence s_sts_read_setup;
      rd_sts && prdata_q[STS_SETUP_BIT] && !pkt_done;
   endsequence

   AST_STALL_IN: assert property (s_stalled_in |=> HS_VALID && HS_KIND == HS_STALL)
      else $error("Stalled IN not answered");
   AST_SETUP_NO_STALL: assert property (tok_hit && TOK_KIND == TOK_SETUP && state_q == ST_IDLE
      |=> state_q == ST_RECV && pend_q == HS_ACK)
      else $error("SETUP was stalled");
   AST_ISO_NO_NAK: assert property (HS_VALID && cfg_q[CFG_ISO_BIT] && $stable(cfg_q) |-> HS_KIND != HS_NAK)
      else $error("NAK on iso endpoint");
   AST_DISABLED_QUIET: assert property (state_q == ST_IDLE && !cfg_q[CFG_EN_BIT]
      |=> state_q == ST_IDLE && !HS_VALID)
      else $error("Disabled endpoint responded");
   AST_CRC_HELD: assert property (state_q == ST_RECV && seen_q != CRC_BYTES + 2'h1 && !test_q |-> !f_push)
      else $error("PID or CRC byte pushed");
   AST_ERR_SET: assert property (pkt_done && RX_MEDIA_ERR |=> err_q && !HS_VALID)
      else $error("Media error not flagged");
   AST_SETUP_CLEAR: assert property (s_sts_read_setup |=> !setup_q)
      else $error("Setup flag survived read");
   AST_ISO_NO_NAK_PEND: assert property (tok_hit && TOK_KIND == TOK_OUT && state_q == ST_IDLE
      && cfg_q[CFG_ISO_BIT] && !cfg_q[CFG_STALL_BIT] |=> pend_q != HS_NAK)
      else $error("NAK owed on iso endpoint");
   AST_RCOUNT_SAT: assert property (f_count > ($clog2(DEPTH)+1)'(RCOUNT_MAX) |-> sts_word[3:0] == RCOUNT_MAX)
      else $error("Count not saturated");
   AST_FLUSH_EMPTY: assert property (flush_q && state_q == ST_IDLE |=> f_empty && !flush_q)
      else $error("Flush did not empty FIFO");

endmodule : uep_endpoint

`default_nettype wire

// ===== test/uep_host_model.sv
// Host side of the full-speed bus: sends tokens and data packets, notes the handshake.
// Assumes the endpoint answers within three cycles of a token or a packet end.
`default_nettype none
module uep_host_model
   import uep_pkg::*;
(
   input  wire logic     clk,
   output logic          tok_valid,
   output var uep_tok_e  tok_kind,
   output logic [6:0]    tok_addr,
   output logic [3:0]    tok_ep,
   output logic          rx_valid,
   output logic [7:0]    rx_byte,
   output logic          rx_end,
   output logic          rx_err,
   input  wire logic     hs_valid,
   input  wire uep_hs_e  hs_kind
);
   timeunit 1ns;
   timeprecision 1ps;
   uep_hs_e hs_got; // Last handshake seen, HS_NONE if silent
   // Quiet bus at time zero
   initial
   begin
      {tok_valid, rx_valid, rx_end, rx_err, tok_addr, tok_ep, rx_byte} = '0;
      tok_kind = TOK_SOF;
      hs_got = HS_NONE;
   end
   // Token, then PID, payload 8'ha0+i and two CRC bytes for OUT or SETUP
   task automatic xfer(input uep_tok_e k, input logic [3:0] ep, input logic [7:0] pid,
                       input int n, input logic err);
      hs_got = HS_NONE;
      @(posedge clk);
      tok_valid <= 1'b1;
      tok_kind <= k;
      tok_addr <= 7'h12;
      tok_ep <= ep;
      @(posedge clk);
      tok_valid <= 1'b0;
      tok_addr <= ~7'h12; // Released token lines must not match by accident
      tok_ep <= ~ep;
      if (k != TOK_IN)
      begin
         for (int i = 0; i < n + 3; i++)
         begin
            @(posedge clk);
            rx_valid <= 1'b1;
            rx_byte <= (i == 0) ? pid : (i > n) ? 8'h5a : 8'ha0 + 8'(i - 1);
         end
         @(posedge clk);
         rx_valid <= 1'b0;
         rx_byte <= ~rx_byte; // Released line must not look like data
         rx_end <= 1'b1;
         rx_err <= err;
         @(posedge clk);
         rx_end <= 1'b0;
         rx_err <= ~err;
      end
      // Handshake is registered, so it is read as settled at each edge
      repeat (3)
      begin
         @(posedge clk);
         if (hs_valid === 1'b1) hs_got = hs_kind;
      end
   endtask : xfer
endmodule : uep_host_model
`default_nettype wire

// ===== test/uep_endpoint_tb_top.sv
// Bench: APB register tasks and host traffic through uep_host_model.
// Assumes a zero-wait APB slave; a bounded wait still guards PREADY.
`default_nettype none
module uep_endpoint_tb_top;
   import uep_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, tx_en = 0, frame_lsb = 0;
   logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
   logic        pready, pslverr, tok_valid, rx_valid, rx_end, rx_err, hs_valid, err;
   logic [6:0]  tok_addr;
   logic [3:0]  tok_ep;
   logic [7:0]  rx_byte;
   uep_tok_e    tok_kind;
   uep_hs_e     hs_kind;
   int          n_fail = 0, checks_done = 0;
   always #4 core_clk = ~core_clk;
   uep_endpoint uep_endpoint_inst (.CORE_CLK(core_clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .TOK_VALID(tok_valid), .TOK_KIND(tok_kind), .TOK_ADDR(tok_addr),
      .TOK_EP(tok_ep), .RX_BYTE_VALID(rx_valid), .RX_BYTE(rx_byte), .RX_END(rx_end),
      .RX_MEDIA_ERR(rx_err), .TX_ENABLED(tx_en), .FRAME_LSB(frame_lsb), .HS_VALID(hs_valid),
      .HS_KIND(hs_kind));
   uep_host_model uep_host_model_inst (.clk(core_clk), .tok_valid(tok_valid), .tok_kind(tok_kind),
      .tok_addr(tok_addr), .tok_ep(tok_ep), .rx_valid(rx_valid), .rx_byte(rx_byte),
      .rx_end(rx_end), .rx_err(rx_err), .hs_valid(hs_valid), .hs_kind(hs_kind));
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : print_verdict
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         $display("wrong value %s expected %h seen %h", nm, exp, got);
         n_fail++;
      end
   endtask : chk
   // One APB transfer; an idle edge first so strobes never change twice in a step
   task automatic apb(input logic wr, input logic [31:0] idx, input logic [31:0] wd);
      int k;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= 32'(idx << 2);
      pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge core_clk);
         k++;
      end
      while (pready !== 1'b1 && k < 16);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         $display("wrong value pready expected 1 seen %b", pready);
         n_fail++;
         print_verdict();
      end
   endtask : apb
   task automatic rdc(input string nm, input logic [31:0] idx, input logic [31:0] exp, input logic [31:0] m);
      apb(1'b0, idx, 32'h0);
      chk(nm, exp, rd & m);
   endtask : rdc
   task automatic hs(input uep_hs_e exp);
      chk("handshake", 32'(exp), 32'(uep_host_model_inst.hs_got));
   endtask : hs
   // Main sequence
   initial
   begin
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      rdc("config", EP_CFG_IDX, 32'h0, '1);
      rdc("status", RX_STS_IDX, 32'h0, '1);
      apb(1'b1, EP_CFG_IDX, 32'hffff);
      rdc("config", EP_CFG_IDX, 32'h00bf, '1);
      apb(1'b0, 32'h50001890, 32'h0);
      chk("pslverr", 32'h1, {31'h0, err});
      $display("test registers done");
      apb(1'b1, FUNC_ADR_IDX, 32'h12);
      apb(1'b1, EP_CFG_IDX, 32'h15);
      apb(1'b1, RX_CTRL_IDX, 32'h1);
      uep_host_model_inst.xfer(TOK_OUT, 4'h5, PID_DATA1, 3, 1'b0);
      hs(HS_ACK);
      rdc("status", RX_STS_IDX, 32'h33, '1);
      for (int i = 0; i < 3; i++) rdc("data", RX_DATA_IDX, 32'ha0 + i, '1);
      rdc("status", RX_STS_IDX, 32'h0, '1);
      uep_host_model_inst.xfer(TOK_OUT, 4'h5, PID_DATA0, 1, 1'b0);
      hs(HS_NAK);
      uep_host_model_inst.xfer(TOK_OUT, 4'h4, PID_DATA0, 1, 1'b0);
      hs(HS_NONE);
      apb(1'b1, EP_CFG_IDX, 32'h05);
      uep_host_model_inst.xfer(TOK_OUT, 4'h5, PID_DATA0, 1, 1'b0);
      hs(HS_NONE);
      $display("test receive done");
      apb(1'b1, EP_CFG_IDX, 32'h95);
      uep_host_model_inst.xfer(TOK_SETUP, 4'h5, PID_DATA0, 2, 1'b0);
      hs(HS_ACK);
      rdc("status", RX_STS_IDX, 32'h52, '1);
      tx_en <= 1'b1;
      uep_host_model_inst.xfer(TOK_IN, 4'h5, PID_DATA0, 0, 1'b0);
      hs(HS_STALL);
      apb(1'b1, RX_CTRL_IDX, 32'h1);
      uep_host_model_inst.xfer(TOK_OUT, 4'h5, PID_DATA0, 1, 1'b0);
      hs(HS_STALL);
      apb(1'b1, RX_CTRL_IDX, 32'h4);
      uep_host_model_inst.xfer(TOK_SETUP, 4'h5, PID_DATA0, 1, 1'b0);
      hs(HS_NONE);
      $display("test stall done");
      apb(1'b1, RX_CTRL_IDX, 32'h8);
      apb(1'b1, EP_CFG_IDX, 32'h15);
      apb(1'b1, RX_CTRL_IDX, 32'h1);
      uep_host_model_inst.xfer(TOK_OUT, 4'h5, PID_DATA0, 2, 1'b1);
      rdc("status err", RX_STS_IDX, 32'h80, 32'h80);
      apb(1'b1, RX_CTRL_IDX, 32'h8);
      rdc("status", RX_STS_IDX, 32'h0, '1);
      apb(1'b1, RX_CTRL_IDX, 32'h1);
      uep_host_model_inst.xfer(TOK_OUT, 4'h5, PID_DATA1, 17, 1'b0);
      hs(HS_ACK);
      rdc("count", RX_STS_IDX, 32'hf, 32'hf);
      apb(1'b1, RX_CTRL_IDX, 32'h8);
      apb(1'b1, EP_CFG_IDX, 32'h35);
      frame_lsb <= 1'b1;
      apb(1'b1, RX_CTRL_IDX, 32'h1);
      uep_host_model_inst.xfer(TOK_OUT, 4'h5, PID_DATA0, 1, 1'b0);
      hs(HS_NONE);
      rdc("status iso", RX_STS_IDX, 32'h21, 32'h2f);
      uep_host_model_inst.xfer(TOK_OUT, 4'h5, PID_DATA0, 1, 1'b0);
      hs(HS_NONE);
      apb(1'b1, RX_CTRL_IDX, 32'h8);
      apb(1'b1, RX_DATA_IDX, 32'h55);
      rdc("count", RX_STS_IDX, 32'h0, 32'hf);
      apb(1'b1, RX_CTRL_IDX, 32'h100);
      apb(1'b1, RX_DATA_IDX, 32'h77);
      rdc("test data", RX_DATA_IDX, 32'h77, 32'hff);
      $display("test error iso done");
      print_verdict();
   end
endmodule : uep_endpoint_tb_top
`default_nettype wire
